// [rtl/charger_regs_pkg.sv]
// Purpose : constants shared by the charger fault and status register group
// Assumes : registers reached over the two-wire serial bus at their printed offsets
// Notes   : bit positions are within an 8-bit register
package charger_regs_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_FAULT_FLAGS  = 8'h09;
  localparam logic [7:0] OFS_INPUT_STATUS = 8'h0A;
  localparam logic [7:0] OFS_RESET_PART   = 8'h0B;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_TIMER_EXPIRY   = 7;
  localparam int BIT_BOOST_FAULT    = 6;
  localparam int POS_CHARGE_FAULT   = 4;
  localparam int BIT_CELL_OV        = 3;
  localparam int POS_THERM_ZONE     = 0;
  localparam int BIT_SOURCE_PRESENT = 7;
  localparam int BIT_VLIM_ACTIVE    = 6;
  localparam int BIT_ILIM_ACTIVE    = 5;
  localparam int BIT_STATUS_RSVD    = 4;
  localparam int BIT_FINISH_TIMER   = 3;
  localparam int BIT_INPUT_OV       = 2;
  localparam int BIT_VLIM_MASK      = 1;
  localparam int BIT_ILIM_MASK      = 0;
  localparam int BIT_DEFAULTS_CMD   = 7;
  localparam int POS_PART_CODE      = 3;
  localparam int BIT_MAKER          = 2;
  localparam int POS_REVISION       = 0;

  // ****************************************
  // reset values and encodings
  // ****************************************
  localparam logic       MASK_RESET       = 1'b0;
  localparam logic       RSVD_READ_VALUE  = 1'b0;
  localparam logic [1:0] CHG_NORMAL       = 2'h0;
  localparam logic [1:0] CHG_INPUT_FAULT  = 2'h1;
  localparam logic [1:0] CHG_THERMAL_SD   = 2'h2;
  localparam logic [1:0] CHG_SAFETY_TIMER = 2'h3;
  localparam logic [2:0] ZONE_NORMAL      = 3'h0;
  localparam logic [2:0] ZONE_WARM        = 3'h2;
  localparam logic [2:0] ZONE_COOL        = 3'h3;
  localparam logic [2:0] ZONE_COLD        = 3'h5;
  localparam logic [2:0] ZONE_HOT         = 3'h6;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

  // ****************************************
  // serial slave states
  // ****************************************
  typedef enum logic [6:0] {
    S_IDLE = 7'b000_0001,
    S_ADDR = 7'b000_0010,
    S_AACK = 7'b000_0100,
    S_WR   = 7'b000_1000,
    S_WACK = 7'b001_0000,
    S_RD   = 7'b010_0000,
    S_RACK = 7'b100_0000
  } serial_state_t;

endpackage

// [rtl/charger_fault_status_regs.sv]
// Purpose : fault, status and identification registers of a charger, on a two-wire slave
// Assumes : scl and sda are synchronous to clk and change far slower than it
// Notes   : sda is open-drain: sda_out is always low, sda_oe pulls the line
`timescale 1ns/1ps

module charger_fault_status_regs #(
  parameter logic [6:0] DEV_ADDR  = 7'h50,
  parameter logic [3:0] PART_CODE = 4'h5,   // arbitrary value
  parameter logic       MAKER_BIT = 1'b0,   // arbitrary value
  parameter logic [1:0] REVISION  = 2'h1    // arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       watchdog_expired,
  input  wire logic       boost_overload,
  input  wire logic       boost_input_ov,
  input  wire logic       boost_battery_low,
  input  wire logic       input_fault,
  input  wire logic       thermal_shutdown,
  input  wire logic       safety_timer_expired,
  input  wire logic       battery_overvoltage,
  input  wire logic       boost_mode,
  input  wire logic       zone_warm,
  input  wire logic       zone_cool,
  input  wire logic       zone_cold,
  input  wire logic       zone_hot,
  input  wire logic       input_source_present,
  input  wire logic       input_voltage_limit_active,
  input  wire logic       input_current_limit_active,
  input  wire logic       finish_timer_running,
  input  wire logic       input_overvoltage_active,
  output logic            irq_pulse,
  output logic            defaults_restore,
  output logic            safety_timer_restart
);

  typedef struct packed {
    charger_regs_pkg::serial_state_t st;
    logic       scl_q;
    logic       sda_q;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic       rw;
    logic       first;
    logic       oe;
    logic       vmask;
    logic       imask;
    logic       cmd;
    logic       vlim_q;
    logic       ilim_q;
    logic       irq;
    logic       restore;
    logic       timer_rst;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic [1:0] charge_code;
  logic [2:0] zone_code;
  logic [7:0] fault_byte;
  logic [7:0] status_byte;
  logic [7:0] id_byte;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       vlim_event;
  logic       ilim_event;

  if (DEV_ADDR == 7'h00) begin : g_addr_check
    $error("general call address cannot be the slave address");
  end

  // ****************************************
  // read-back value assembly
  // ****************************************
  always_comb begin
    charge_code = safety_timer_expired ? charger_regs_pkg::CHG_SAFETY_TIMER :
                  thermal_shutdown     ? charger_regs_pkg::CHG_THERMAL_SD   :
                  input_fault          ? charger_regs_pkg::CHG_INPUT_FAULT  :
                                         charger_regs_pkg::CHG_NORMAL;
    zone_code = zone_hot                   ? charger_regs_pkg::ZONE_HOT  :
                zone_cold                  ? charger_regs_pkg::ZONE_COLD :
                (zone_warm && !boost_mode) ? charger_regs_pkg::ZONE_WARM :
                (zone_cool && !boost_mode) ? charger_regs_pkg::ZONE_COOL :
                                             charger_regs_pkg::ZONE_NORMAL;
    fault_byte = '0;
    fault_byte[charger_regs_pkg::BIT_TIMER_EXPIRY] = watchdog_expired;
    fault_byte[charger_regs_pkg::BIT_BOOST_FAULT] =
      boost_overload | boost_input_ov | boost_battery_low;
    fault_byte[charger_regs_pkg::POS_CHARGE_FAULT +: 2] = charge_code;
    fault_byte[charger_regs_pkg::BIT_CELL_OV] = battery_overvoltage;
    fault_byte[charger_regs_pkg::POS_THERM_ZONE +: 3] = zone_code;
    status_byte = '0;
    status_byte[charger_regs_pkg::BIT_SOURCE_PRESENT] = input_source_present;
    status_byte[charger_regs_pkg::BIT_VLIM_ACTIVE] = input_voltage_limit_active;
    status_byte[charger_regs_pkg::BIT_ILIM_ACTIVE] = input_current_limit_active;
    status_byte[charger_regs_pkg::BIT_STATUS_RSVD] = charger_regs_pkg::RSVD_READ_VALUE;
    status_byte[charger_regs_pkg::BIT_FINISH_TIMER] = finish_timer_running;
    status_byte[charger_regs_pkg::BIT_INPUT_OV] = input_overvoltage_active;
    status_byte[charger_regs_pkg::BIT_VLIM_MASK] = s_reg.vmask;
    status_byte[charger_regs_pkg::BIT_ILIM_MASK] = s_reg.imask;
    id_byte = '0;
    id_byte[charger_regs_pkg::BIT_DEFAULTS_CMD] = s_reg.cmd;
    id_byte[charger_regs_pkg::POS_PART_CODE +: 4] = PART_CODE;
    id_byte[charger_regs_pkg::BIT_MAKER] = MAKER_BIT;
    id_byte[charger_regs_pkg::POS_REVISION +: 2] = REVISION;
  end

  function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] f,
                                          input logic [7:0] st, input logic [7:0] id);
    read_reg = (a == charger_regs_pkg::OFS_FAULT_FLAGS)  ? f  :
               (a == charger_regs_pkg::OFS_INPUT_STATUS) ? st :
               (a == charger_regs_pkg::OFS_RESET_PART)   ? id : 8'h00;
  endfunction

  assign scl_rise   = scl & ~s_reg.scl_q;
  assign scl_fall   = ~scl & s_reg.scl_q;
  assign bus_start  = scl & s_reg.scl_q & s_reg.sda_q & ~sda_in;
  assign bus_stop   = scl & s_reg.scl_q & ~s_reg.sda_q & sda_in;
  assign vlim_event = input_voltage_limit_active & ~s_reg.vlim_q;
  assign ilim_event = input_current_limit_active & ~s_reg.ilim_q;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [7:0] rd;
    rd = 8'h00;
    s_next = s_reg;
    s_next.scl_q  = scl;
    s_next.sda_q  = sda_in;
    s_next.vlim_q = input_voltage_limit_active;
    s_next.ilim_q = input_current_limit_active;
    s_next.irq = (vlim_event & ~s_reg.vmask) | (ilim_event & ~s_reg.imask);
    s_next.restore   = s_reg.cmd;
    s_next.timer_rst = s_reg.cmd;
    if (s_reg.cmd) begin
      s_next.cmd   = 1'b0;
      s_next.vmask = charger_regs_pkg::MASK_RESET;
      s_next.imask = charger_regs_pkg::MASK_RESET;
    end
    if (bus_stop) begin
      s_next.st = charger_regs_pkg::S_IDLE;
      s_next.oe = 1'b0;
    end else if (bus_start) begin
      s_next.st  = charger_regs_pkg::S_ADDR;
      s_next.cnt = '0;
      s_next.oe  = 1'b0;
    end else begin
      unique case (s_reg.st)
        charger_regs_pkg::S_IDLE: begin
          s_next.oe = 1'b0;
        end
        charger_regs_pkg::S_ADDR: begin
          if (scl_rise) begin
            s_next.sh  = {s_reg.sh[6:0], sda_in};
            s_next.cnt = s_reg.cnt + 4'h1;
          end else if (scl_fall && s_reg.cnt == charger_regs_pkg::BITS_PER_BYTE) begin
            if (s_reg.sh[7:1] == DEV_ADDR) begin
              s_next.oe = 1'b1;
              s_next.rw = s_reg.sh[0];
              s_next.st = charger_regs_pkg::S_AACK;
            end else begin
              s_next.st = charger_regs_pkg::S_IDLE;
            end
          end
        end
        charger_regs_pkg::S_AACK: begin
          if (scl_fall) begin
            s_next.cnt = '0;
            if (s_reg.rw) begin
              rd = read_reg(s_reg.ptr, fault_byte, status_byte, id_byte);
              s_next.sh = rd;
              s_next.oe = ~rd[7];
              s_next.st = charger_regs_pkg::S_RD;
            end else begin
              s_next.oe    = 1'b0;
              s_next.first = 1'b1;
              s_next.st    = charger_regs_pkg::S_WR;
            end
          end
        end
        charger_regs_pkg::S_WR: begin
          if (scl_rise) begin
            s_next.sh  = {s_reg.sh[6:0], sda_in};
            s_next.cnt = s_reg.cnt + 4'h1;
          end else if (scl_fall && s_reg.cnt == charger_regs_pkg::BITS_PER_BYTE) begin
            s_next.oe = 1'b1;
            s_next.st = charger_regs_pkg::S_WACK;
            if (s_reg.first) begin
              s_next.ptr   = s_reg.sh;
              s_next.first = 1'b0;
            end else begin
              s_next.ptr = s_reg.ptr + 8'h01;
              if (s_reg.ptr == charger_regs_pkg::OFS_INPUT_STATUS) begin
                s_next.vmask = s_reg.sh[charger_regs_pkg::BIT_VLIM_MASK];
                s_next.imask = s_reg.sh[charger_regs_pkg::BIT_ILIM_MASK];
              end else if (s_reg.ptr == charger_regs_pkg::OFS_RESET_PART &&
                           s_reg.sh[charger_regs_pkg::BIT_DEFAULTS_CMD]) begin
                s_next.cmd = 1'b1;
              end
            end
          end
        end
        charger_regs_pkg::S_WACK: begin
          if (scl_fall) begin
            s_next.oe  = 1'b0;
            s_next.cnt = '0;
            s_next.st  = charger_regs_pkg::S_WR;
          end
        end
        charger_regs_pkg::S_RD: begin
          if (scl_rise) begin
            s_next.cnt = s_reg.cnt + 4'h1;
          end else if (scl_fall) begin
            if (s_reg.cnt == charger_regs_pkg::BITS_PER_BYTE) begin
              s_next.oe = 1'b0;
              s_next.st = charger_regs_pkg::S_RACK;
            end else begin
              s_next.oe = ~s_reg.sh[6];
              s_next.sh = {s_reg.sh[6:0], 1'b0};
            end
          end
        end
        charger_regs_pkg::S_RACK: begin
          if (scl_rise && sda_in) begin
            s_next.st = charger_regs_pkg::S_IDLE;
          end else if (scl_fall) begin
            rd = read_reg(s_reg.ptr + 8'h01, fault_byte, status_byte, id_byte);
            s_next.ptr = s_reg.ptr + 8'h01;
            s_next.sh  = rd;
            s_next.oe  = ~rd[7];
            s_next.cnt = '0;
            s_next.st  = charger_regs_pkg::S_RD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg       <= '0;
      s_reg.st    <= charger_regs_pkg::S_IDLE;
      s_reg.scl_q <= 1'b1;
      s_reg.sda_q <= 1'b1;
      s_reg.vmask <= charger_regs_pkg::MASK_RESET;
      s_reg.imask <= charger_regs_pkg::MASK_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sda_out              = 1'b0;
  assign sda_oe               = s_reg.oe;
  assign irq_pulse            = s_reg.irq;
  assign defaults_restore     = s_reg.restore;
  assign safety_timer_restart = s_reg.timer_rst;

  // ****************************************
  // assertions
  // ****************************************
  property p_wd_flag;
    @(posedge clk) disable iff (!rstn)
      fault_byte[charger_regs_pkg::BIT_TIMER_EXPIRY] == watchdog_expired;
  endproperty
  a_wd_flag: assert property (p_wd_flag) else $error("watchdog flag wrong");
  property p_chg_input;
    @(posedge clk) disable iff (!rstn)
      (input_fault && !thermal_shutdown && !safety_timer_expired) |->
        charge_code == charger_regs_pkg::CHG_INPUT_FAULT;
  endproperty
  a_chg_input: assert property (p_chg_input) else $error("input fault code wrong");
  property p_boost_zone;
    @(posedge clk) disable iff (!rstn)
      boost_mode |-> zone_code inside {3'h0, 3'h5, 3'h6};
  endproperty
  a_boost_zone: assert property (p_boost_zone) else $error("illegal boost zone");
  property p_vlim_irq;
    @(posedge clk) disable iff (!rstn)
      (input_voltage_limit_active && !s_reg.vlim_q && !s_reg.vmask) |=> irq_pulse;
  endproperty
  a_vlim_irq: assert property (p_vlim_irq) else $error("voltage limit pulse lost");
  property p_irq_cause;
    @(posedge clk) disable iff (!rstn)
      irq_pulse |-> $past(vlim_event && !s_reg.vmask) || $past(ilim_event && !s_reg.imask);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("pulse without unmasked event");
  property p_restore_seq;
    @(posedge clk) disable iff (!rstn)
      $rose(s_reg.cmd) |=> (defaults_restore && safety_timer_restart) ##1 !defaults_restore;
  endproperty
  a_restore_seq: assert property (p_restore_seq) else $error("restore sequence wrong");
  property p_cmd_clear;
    @(posedge clk) disable iff (!rstn)
      s_reg.cmd |=> !s_reg.cmd && !s_reg.vmask && !s_reg.imask;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("command did not clear");
  property p_id_fixed;
    @(posedge clk) disable iff (!rstn)
      id_byte[6:0] == {PART_CODE, MAKER_BIT, REVISION};
  endproperty
  a_id_fixed: assert property (p_id_fixed) else $error("identity changed");
  property p_rsvd;
    @(posedge clk) disable iff (!rstn)
      status_byte[charger_regs_pkg::BIT_STATUS_RSVD] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit not zero");
  property p_mask_hold;
    @(posedge clk) disable iff (!rstn)
      (s_reg.st != charger_regs_pkg::S_WR && !s_reg.cmd) |=> $stable(s_reg.vmask);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask changed without write");

  c_restore: cover property (@(posedge clk) disable iff (!rstn) defaults_restore);
  c_irq: cover property (@(posedge clk) disable iff (!rstn) irq_pulse);
  c_read: cover property (@(posedge clk) disable iff (!rstn)
    s_reg.st == charger_regs_pkg::S_RACK ##1 s_reg.st == charger_regs_pkg::S_RD);

endmodule

// [tb/i2c_host_model.sv]
// Purpose : two-wire host that drives the serial clock and pulls the data line
// Assumes : the bench resolves the open-drain data line with a pull-up
// Notes   : lines change only at falling clk edges; one bit spans ten clocks
`timescale 1ns/1ps

module i2c_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);

  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // ****************************************
  // bus conditions and bits
  // ****************************************
  // start and repeated start: data falls while the clock is high
  task automatic start();
    sda_pull = 1'b0;
    wait_clk(3);
    scl = 1'b1;
    wait_clk(3);
    sda_pull = 1'b1;
    wait_clk(3);
    scl = 1'b0;
  endtask

  task automatic stop();
    sda_pull = 1'b1;
    wait_clk(3);
    scl = 1'b1;
    wait_clk(3);
    sda_pull = 1'b0;
    wait_clk(3);
  endtask

  // data set while the clock is low, sampled in the middle of the high phase
  task automatic bit_xfer(input logic b, output logic r);
    wait_clk(2);
    sda_pull = !b;
    wait_clk(3);
    scl = 1'b1;
    wait_clk(3);
    r = sda;
    wait_clk(2);
    scl = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, ack_n);
  endtask

  task automatic recv_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(nack, r);
  endtask

  // ****************************************
  // register frames
  // ****************************************
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                           input logic [7:0] d, output logic ack_n);
    logic a0;
    logic a1;
    logic a2;
    start();
    send_byte({dev, 1'b0}, a0);
    send_byte(ofs, a1);
    send_byte(d, a2);
    stop();
    ack_n = a0 | a1 | a2;
  endtask

  // pointer set by a write frame, then a repeated start and one byte read
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs,
                          output logic [7:0] d);
    logic a;
    start();
    send_byte({dev, 1'b0}, a);
    send_byte(ofs, a);
    start();
    send_byte({dev, 1'b1}, a);
    recv_byte(1'b1, d);
    stop();
  endtask

  // two data bytes in one frame: the pointer steps after the first
  task automatic write_pair(input logic [6:0] dev, input logic [7:0] ofs,
                            input logic [7:0] d0, input logic [7:0] d1,
                            output logic ack_n);
    logic a0;
    logic a1;
    logic a2;
    logic a3;
    start();
    send_byte({dev, 1'b0}, a0);
    send_byte(ofs, a1);
    send_byte(d0, a2);
    send_byte(d1, a3);
    stop();
    ack_n = a0 | a1 | a2 | a3;
  endtask

  // two bytes read in one frame: the first is acknowledged, the second is not
  task automatic read_pair(input logic [6:0] dev, input logic [7:0] ofs,
                           output logic [7:0] d0, output logic [7:0] d1);
    logic a;
    start();
    send_byte({dev, 1'b0}, a);
    send_byte(ofs, a);
    start();
    send_byte({dev, 1'b1}, a);
    recv_byte(1'b0, d0);
    recv_byte(1'b1, d1);
    stop();
  endtask

endmodule

// [tb/charger_fault_status_regs_tb.sv]
// Purpose : self-checking bench for the charger fault and status registers
// Assumes : all register traffic goes through the two-wire host model
// Notes   : analog levels are one vector, counters track the output pulses
`timescale 1ns/1ps

module charger_fault_status_regs_tb;

  localparam logic [6:0] DEV       = 7'h50;
  localparam logic [3:0] PART_CODE = 4'hA;  // arbitrary value
  localparam logic       MAKER_BIT = 1'b1;  // arbitrary value
  localparam logic [1:0] REVISION  = 2'h2;  // arbitrary value
  localparam logic [7:0] ID_VALUE  = {1'b0, PART_CODE, MAKER_BIT, REVISION};

  logic        clk;
  logic        rstn;
  logic        scl;
  logic        sda_pull;
  logic        sda_line;
  logic        sda_out;
  logic        sda_oe;
  logic [17:0] ana;
  logic        irq_pulse;
  logic        defaults_restore;
  logic        safety_timer_restart;
  logic        a;
  logic [7:0]  d0;
  logic [7:0]  d1;
  int          failures   = 0;
  int          n_compared = 0;
  int          n_irq      = 0;
  int          n_rst      = 0;
  int          n_tmr      = 0;
  int          base;
  int          base_t;

  logic [17:0] c_ana [20] = '{18'h2_0000, 18'h1_0000, 18'h0_8000, 18'h0_4000, 18'h0_2000,
    18'h0_1000, 18'h0_0800, 18'h0_0400, 18'h0_0100, 18'h0_0080, 18'h0_0040, 18'h0_0020,
    18'h0_0300, 18'h0_0240, 18'h0_0220, 18'h0_0010, 18'h0_0008, 18'h0_0004, 18'h0_0002,
    18'h0_001F};
  logic [7:0]  c_exp [20] = '{8'h80, 8'h40, 8'h40, 8'h40, 8'h10, 8'h20, 8'h30, 8'h08,
    8'h02, 8'h03, 8'h05, 8'h06, 8'h00, 8'h05, 8'h06, 8'h80, 8'h40, 8'h20, 8'h08, 8'hEC};

  // open-drain data line with pull-up
  assign sda_line = !(sda_pull || (sda_oe && !sda_out));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (irq_pulse === 1'b1) n_irq <= n_irq + 1;
    if (defaults_restore === 1'b1) n_rst <= n_rst + 1;
    if (safety_timer_restart === 1'b1) n_tmr <= n_tmr + 1;
  end

  charger_fault_status_regs #(
    .DEV_ADDR (DEV),
    .PART_CODE(PART_CODE),
    .MAKER_BIT(MAKER_BIT),
    .REVISION (REVISION)
  ) i_charger_fault_status_regs (
    .clk(clk), .rstn(rstn), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .watchdog_expired(ana[17]), .boost_overload(ana[16]),
    .boost_input_ov(ana[15]), .boost_battery_low(ana[14]), .input_fault(ana[13]),
    .thermal_shutdown(ana[12]), .safety_timer_expired(ana[11]),
    .battery_overvoltage(ana[10]), .boost_mode(ana[9]), .zone_warm(ana[8]),
    .zone_cool(ana[7]), .zone_cold(ana[6]), .zone_hot(ana[5]),
    .input_source_present(ana[4]), .input_voltage_limit_active(ana[3]),
    .input_current_limit_active(ana[2]), .finish_timer_running(ana[1]),
    .input_overvoltage_active(ana[0]), .irq_pulse(irq_pulse),
    .defaults_restore(defaults_restore), .safety_timer_restart(safety_timer_restart)
  );

  i2c_host_model i_i2c_host_model (
    .clk(clk), .sda(sda_line), .scl(scl), .sda_pull(sda_pull)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] d;
    i_i2c_host_model.read_reg(DEV, ofs, d);
    check(d, exp);
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic ack_n;
    i_i2c_host_model.write_reg(DEV, ofs, d, ack_n);
    check({7'h00, ack_n}, 8'h00);
  endtask

  task automatic pulse_in(input int idx);
    ana[idx] = 1'b1;
    repeat (4) @(negedge clk);
    ana[idx] = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    failures++;
    results();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    ana  = 18'h0_0000;
    rstn = 1'b0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    rd(charger_regs_pkg::OFS_INPUT_STATUS, 8'h00);
    for (int i = 0; i < 20; i++) begin
      ana = c_ana[i];
      rd((i < 15) ? charger_regs_pkg::OFS_FAULT_FLAGS : charger_regs_pkg::OFS_INPUT_STATUS,
         c_exp[i]);
    end
    ana = 18'h0_0000;
    wr(charger_regs_pkg::OFS_FAULT_FLAGS, 8'hFF);
    rd(charger_regs_pkg::OFS_FAULT_FLAGS, 8'h00);
    wr(charger_regs_pkg::OFS_INPUT_STATUS, 8'hFC);
    rd(charger_regs_pkg::OFS_INPUT_STATUS, 8'h00);
    wr(charger_regs_pkg::OFS_RESET_PART, 8'h7F);
    rd(charger_regs_pkg::OFS_RESET_PART, ID_VALUE);
    wr(8'h20, 8'h5A);
    rd(8'h20, 8'h00);
    i_i2c_host_model.write_reg(7'h51, charger_regs_pkg::OFS_INPUT_STATUS, 8'h03, a);
    check({7'h00, a}, 8'h01);
    rd(charger_regs_pkg::OFS_INPUT_STATUS, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(charger_regs_pkg::OFS_INPUT_STATUS, 8'(m));
      rd(charger_regs_pkg::OFS_INPUT_STATUS, 8'(m));
      base = n_irq;
      pulse_in(3);
      check(8'(n_irq - base), {7'h00, (m < 2)});
      base = n_irq;
      pulse_in(2);
      check(8'(n_irq - base), {7'h00, (m % 2 == 0)});
    end
    wr(charger_regs_pkg::OFS_INPUT_STATUS, 8'h01);
    base   = n_rst;
    base_t = n_tmr;
    wr(charger_regs_pkg::OFS_RESET_PART, 8'h00);
    rd(charger_regs_pkg::OFS_INPUT_STATUS, 8'h01);
    check(8'(n_rst - base), 8'h00);
    wr(charger_regs_pkg::OFS_INPUT_STATUS, 8'h03);
    wr(charger_regs_pkg::OFS_RESET_PART, 8'h80);
    check(8'(n_rst - base), 8'h01);
    check(8'(n_tmr - base_t), 8'h01);
    rd(charger_regs_pkg::OFS_INPUT_STATUS, 8'h00);
    rd(charger_regs_pkg::OFS_RESET_PART, ID_VALUE);
    i_i2c_host_model.write_pair(DEV, charger_regs_pkg::OFS_FAULT_FLAGS, 8'hFF, 8'h03, a);
    check({7'h00, a}, 8'h00);
    rd(charger_regs_pkg::OFS_INPUT_STATUS, 8'h03);
    i_i2c_host_model.read_pair(DEV, charger_regs_pkg::OFS_INPUT_STATUS, d0, d1);
    check(d0, 8'h03);
    check(d1, ID_VALUE);
    results();
  end

endmodule
